// ===== logic/synth_port_host.sv
// host controller: APB registers, mode-0 byte shifter, strobe and power-down
// assumes APB master on clk_sys; device samples the serial clock it makes
`timescale 1ns/1ps
`include "synth_port_defs.svh"
module synth_port_host
  import synth_port_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  synth_port_if.host link
);
  host_state_t state;
  word_t data_reg, sh;
  logic pd_reg, go;
  logic [3:0] div;
  logic [5:0] bit_cnt;
  logic [1:0] lock_s;
  wire acc = psel & penable;
  wire busy = (state != h_idle);
  wire half_done = (div == `SCLK_HALF);
  wire frame_start = (state == h_idle) && go;
  wire fall_now = (state == h_shift) && half_done && link.serial_clk;
  wire last_fall = fall_now && (bit_cnt == 6'(`WORD_BITS - 1));

  // true for the three register offsets; anything else answers with an error
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `OFF_CTRL) || (a == `OFF_DATA) || (a == `OFF_STAT);
  endfunction : is_mapped

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc && !is_mapped(paddr);

  // lock input from the device pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) lock_s <= 2'h0;
    else lock_s <= {lock_s[0], link.multiplexed_status_output};
  end

  // register writes; go is a pulse, ignored while busy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= '0;
      pd_reg <= 1'b0;
      go <= 1'b0;
    end else begin
      go <= 1'b0;
      if (acc && pwrite && paddr == `OFF_DATA) data_reg <= pwdata;
      if (acc && pwrite && paddr == `OFF_CTRL) begin
        pd_reg <= pwdata[`CTRL_PD];
        go <= pwdata[`CTRL_GO] & ~busy;
      end
    end
  end

  // read mux
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `OFF_CTRL: prdata <= {30'h0, pd_reg, 1'b0};
        `OFF_DATA: prdata <= data_reg;
        `OFF_STAT: prdata <= {30'h0, lock_s[1], busy};
        default: prdata <= '0;
      endcase
    end
  end

  assign link.power_down = pd_reg;

  // half-period divider; held at zero while idle so every frame starts aligned
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) div <= 4'h0;
    else if (state == h_idle || half_done) div <= 4'h0;
    else div <= div + 4'h1;
  end

  // frame order; commit only after the last fall
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= h_idle;
    end else begin
      unique case (state)
        // wait for a go pulse from the control register
        h_idle: if (go) state <= h_low;
        // strobe low, clock still, one half period of lead
        h_low: if (half_done) state <= h_shift;
        // thirty-two clock periods
        h_shift: if (last_fall) state <= h_commit;
        // one half period of trail before the strobe rises
        h_commit: if (half_done) state <= h_idle;
      endcase
    end
  end

  // four bytes counted as 32 falls
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) bit_cnt <= 6'h0;
    else if (state == h_low && half_done) bit_cnt <= 6'h0;
    else if (fall_now) bit_cnt <= bit_cnt + 6'h1;
  end

  // snapshot taken at go, so a data write during a frame cannot tear it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) sh <= '0;
    else if (frame_start) sh <= data_reg;
    else if (fall_now) sh <= {sh[`WORD_BITS-2:0], 1'b0};
  end

  // clock idles low, toggles per half
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) link.serial_clk <= 1'b0;
    else if (state == h_shift && half_done) link.serial_clk <= ~link.serial_clk;
  end

  // data moves on falls, msb first; a full half period of setup before each rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) link.serial_data <= 1'b0;
    else if (state == h_low && half_done) link.serial_data <= sh[`WORD_BITS-1];
    else if (fall_now) link.serial_data <= sh[`WORD_BITS-2];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) link.load_strobe <= 1'b1;
    else if (frame_start) link.load_strobe <= 1'b0;
    else if (state == h_commit && half_done) link.load_strobe <= 1'b1;
  end
endmodule : synth_port_host

// ===== logic/synth_port_defs.svh
// constants for the three-wire synthesizer write port and its host controller
// assumes inclusion by bare name from both end modules and the package
// Behaviour
// - device shifts data on serial clock rises
// - load strobe rise copies word to latch
// - host holds load strobe low while shifting
// - host sends word as four bytes
// - host raises strobe only after fourth byte
// - host uses clock phase zero timing
// - host drives device power-down input
// - device shows lock on status output; host polls
// - output power from latch four bits 4:3
// - resync phase at second sync after load
`ifndef SYNTH_PORT_DEFS_SVH
`define SYNTH_PORT_DEFS_SVH
`define WORD_BITS 32
`define ADDR_LSB 0
`define ADDR_MSB 2
`define LATCH_COUNT 6
`define PWR_LSB 3
`define PWR_MSB 4
`define PWR_LATCH 4
`define RESYNC_LATCH 3
`define RESYNC_LSB 15
`define RESYNC_MSB 16
`define RESYNC_ON 2'h2
`define DIV_LSB 3
`define DIV_MSB 14
`define SYNC_DIV_DEFAULT 12'h010
`define LOCK_SEL_LATCH 2
`define MUX_LSB 26
`define MUX_MSB 28
`define MUX_LOCK 3'h6
`define OFF_CTRL 8'h00
`define OFF_DATA 8'h04
`define OFF_STAT 8'h08
`define SCLK_HALF 4'h5
`define CTRL_GO 0
`define CTRL_PD 1
`define STAT_BUSY 0
`define STAT_LOCK 1
`endif

// ===== logic/synth_port_pkg.sv
// types shared by both ends of the synthesizer write port
// assumes synth_port_defs.svh for widths
`include "synth_port_defs.svh"
package synth_port_pkg;
  typedef logic [`WORD_BITS-1:0] word_t;
  typedef enum logic [1:0] {
    h_idle = 2'b00,
    h_low = 2'b01,
    h_shift = 2'b10,
    h_commit = 2'b11
  } host_state_t;
endpackage : synth_port_pkg

// ===== logic/synth_port_if.sv
// three-wire link between host controller and synthesizer port
// assumes both ends share no clock; the device samples the serial clock
`timescale 1ns/1ps
interface synth_port_if;
  logic serial_clk;
  logic serial_data;
  logic load_strobe;
  logic power_down;
  logic multiplexed_status_output;
  modport host (
    output serial_clk,
    output serial_data,
    output load_strobe,
    output power_down,
    input multiplexed_status_output
  );
  modport device (
    input serial_clk,
    input serial_data,
    input load_strobe,
    input power_down,
    output multiplexed_status_output
  );
endinterface : synth_port_if

// ===== logic/synth_port_device.sv
// synthesizer side of the write port: shift register, latches, status pin
// assumes link pins are asynchronous to clk_sys and sampled by two flops
`timescale 1ns/1ps
`include "synth_port_defs.svh"
module synth_port_device
  import synth_port_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // link
  synth_port_if.device link,
  // synthesizer core
  input wire logic pll_locked,
  input wire logic sync_tick,
  output logic [1:0] output_power_field,
  output logic powered_down,
  output logic resync_pulse,
  output logic [`WORD_BITS-1:0] latch_view [`LATCH_COUNT]
);
  logic [2:0] clk_s, le_s, pd_s;
  logic [1:0] dat_s;
  word_t shreg;
  logic [1:0] sync_seen;
  logic resync_armed;

  // two-flop synchronisers, third stage of clk and le for edge finding
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_s <= 3'h0;
      // strobe idles high, so a low reset value would fake a rise after reset
      le_s <= 3'h7;
      pd_s <= 3'h0;
      dat_s <= 2'h0;
    end else begin
      clk_s <= {clk_s[1:0], link.serial_clk};
      le_s <= {le_s[1:0], link.load_strobe};
      pd_s <= {pd_s[1:0], link.power_down};
      dat_s <= {dat_s[0], link.serial_data};
    end
  end

  wire clk_rise = clk_s[1] & ~clk_s[2];
  wire le_rise = le_s[1] & ~le_s[2];
  wire [2:0] addr = shreg[`ADDR_MSB:`ADDR_LSB];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) shreg <= '0;
    else if (clk_rise) shreg <= {shreg[`WORD_BITS-2:0], dat_s[1]};
  end

  // commit on strobe; unknown addresses dropped
  for (genvar i = 0; i < `LATCH_COUNT; i++) begin : g_latch
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) latch_view[i] <= '0;
      else if (le_rise && addr == 3'(i)) latch_view[i] <= shreg;
    end
  end

  assign output_power_field = latch_view[`PWR_LATCH][`PWR_MSB:`PWR_LSB];

  assign powered_down = pd_s[1];

  // resync at second sync after a load, when enabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resync_armed <= 1'b0;
      sync_seen <= 2'h0;
      resync_pulse <= 1'b0;
    end else begin
      resync_pulse <= 1'b0;
      if (le_rise) begin
        resync_armed <= 1'b1;
        sync_seen <= 2'h0;
      end else if (resync_armed && sync_tick) begin
        if (sync_seen == 2'h1) begin
          resync_armed <= 1'b0;
          resync_pulse <=
            (latch_view[`RESYNC_LATCH][`RESYNC_MSB:`RESYNC_LSB] == `RESYNC_ON);
        end
        sync_seen <= sync_seen + 2'h1;
      end
    end
  end

  // lock shown when the status mux selects it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) link.multiplexed_status_output <= 1'b0;
    else link.multiplexed_status_output <=
      (latch_view[`LOCK_SEL_LATCH][`MUX_MSB:`MUX_LSB] == `MUX_LOCK) & pll_locked;
  end
endmodule : synth_port_device

// ===== tb/synth_port_checker.sv
// link checks between host controller and synthesizer port
// assumes the bench instantiates it beside the interface instance
`timescale 1ns/1ps
module synth_port_checker (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  // link
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic power_down,
  input wire logic multiplexed_status_output
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic clk_q;
  logic [5:0] rise_cnt;
  // rises per frame; cleared while the strobe is high so a short frame shows up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      rise_cnt <= 6'h00;
    end else begin
      clk_q <= serial_clk;
      if (load_strobe) begin
        rise_cnt <= 6'h00;
      end else if (serial_clk && !clk_q) begin
        rise_cnt <= rise_cnt + 6'h01;
      end
    end
  end
  chk_idle_no_clock: assert property (
    load_strobe |-> !serial_clk) else $error("clock ran with strobe high");
  chk_strobe_lead: assert property (
    $fell(load_strobe) |-> !serial_clk [*8]) else $error("clock too soon after strobe");
  chk_data_steady: assert property (
    serial_clk |-> $stable(serial_data)) else $error("data moved while clock high");
  chk_high_width: assert property (
    $rose(serial_clk) |-> serial_clk [*6] ##1 !serial_clk) else $error("bad high time");
  chk_low_width: assert property (
    $fell(serial_clk) |-> !serial_clk [*6]) else $error("bad low time");
  chk_word_count: assert property (
    $rose(load_strobe) |-> rise_cnt == 6'h20) else $error("word not 32 bits");
  chk_count_limit: assert property (
    !load_strobe |-> rise_cnt <= 6'h20) else $error("too many bits in frame");
  chk_strobe_trail: assert property (
    $rose(load_strobe) |-> !$past(serial_clk, 5)) else $error("strobe rose too early");
endmodule : synth_port_checker

// ===== tb/three_wire_register_write_port_tb.sv
// bench joining host and device through the link; APB drives the host
// assumes zero-wait APB slave and a registered device side
`timescale 1ns/1ps
`include "synth_port_defs.svh"
module three_wire_register_write_port_tb;
  import synth_port_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, pll_locked = 1'b0, sync_tick = 1'b0, powered_down, resync_pulse;
  logic [1:0] output_power_field;
  logic [`WORD_BITS-1:0] latch_view [`LATCH_COUNT];
  word_t exp_l [`LATCH_COUNT];
  int err_count = 0, compares = 0, seen, i;
  synth_port_if link();
  synth_port_host synth_port_host_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  synth_port_device synth_port_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .pll_locked(pll_locked), .sync_tick(sync_tick), .output_power_field(output_power_field),
    .powered_down(powered_down), .resync_pulse(resync_pulse), .latch_view(latch_view));
  synth_port_checker synth_port_checker_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .serial_clk(link.serial_clk), .serial_data(link.serial_data),
    .load_strobe(link.load_strobe), .power_down(link.power_down),
    .multiplexed_status_output(link.multiplexed_status_output));
  initial forever #2.5 clk_sys = ~clk_sys;
  task end_of_test;
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk
  // one APB transfer; an edge always passes first so psel is never set twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      chk("pready", 1, 0);
      end_of_test;
    end
  endtask : apb
  // load a word, wait out busy under a bound, then compare every latch
  task send(input word_t w);
    int n;
    apb(1'b1, `OFF_DATA, w);
    apb(1'b1, `OFF_CTRL, 32'h1);
    n = 0;
    do begin
      apb(1'b0, `OFF_STAT, 32'h0);
      n++;
    end while (rd[`STAT_BUSY] !== 1'b0 && n < 500);
    if (n >= 500) begin
      chk("busy", 0, 1);
      end_of_test;
    end
    repeat (8) @(posedge clk_sys);
    if (w[2:0] < 3'h6) exp_l[w[2:0]] = w;
    for (int k = 0; k < `LATCH_COUNT; k++) chk("latch", exp_l[k], latch_view[k]);
  endtask : send
  // pulse the sync timer and count resync pulses seen at settled falling edges
  task tick(output int cnt);
    @(posedge clk_sys);
    sync_tick <= 1'b1;
    @(posedge clk_sys);
    sync_tick <= 1'b0;
    cnt = 0;
    repeat (6) begin
      @(negedge clk_sys);
      cnt += resync_pulse;
    end
  endtask : tick
  initial begin
    for (i = 0; i < `LATCH_COUNT; i++) exp_l[i] = 32'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    // every address, unused ones must leave latches alone
    for (i = 0; i < 8; i++) send(32'hA5C3_E1F0 | i);
    send(32'h0000_000C);
    chk("power", 32'h1, {30'h0, output_power_field});
    $display("latch test done");
    send(32'h1800_0002);
    apb(1'b0, `OFF_DATA, 32'h0);
    chk("data_readback", 32'h1800_0002, rd);
    for (i = 1; i >= 0; i--) begin
      pll_locked <= i[0];
      repeat (4) @(posedge clk_sys);
      apb(1'b0, `OFF_STAT, 32'h0);
      chk("lock", i, {31'h0, rd[`STAT_LOCK]});
      chk("status_pin", i, {31'h0, link.multiplexed_status_output});
      apb(1'b1, `OFF_CTRL, {30'h0, i[0], 1'b0});
      repeat (4) @(posedge clk_sys);
      chk("power_down", i, {31'h0, powered_down});
      apb(1'b0, `OFF_CTRL, 32'h0);
      chk("ctrl_readback", {30'h0, i[0], 1'b0}, rd);
    end
    $display("lock and power-down test done");
    send(32'h0001_0003);
    tick(seen);
    chk("resync_first", 0, seen);
    tick(seen);
    chk("resync_second", 1, seen);
    send(32'h0000_8003);
    tick(seen);
    tick(seen);
    chk("resync_off", 0, seen);
    $display("resync test done");
    apb(1'b0, 8'h0C, 32'h0);
    chk("slverr", 1, {31'h0, er});
    chk("unmapped", 0, rd);
    $display("unmapped test done");
    end_of_test;
  end
endmodule : three_wire_register_write_port_tb
